/* core/els_fifo.sv */
`timescale 1ns/1ps
module els_fifo #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 8,
    parameter int unsigned AW = 3
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [WIDTH-1:0] in_data,
    input wire logic in_valid,
    output logic in_ready,
    output logic [WIDTH-1:0] out_data,
    output logic out_valid,
    input wire logic out_ready
);
    typedef struct packed {
        logic [AW:0] wp;
        logic [AW:0] rp;
    } els_fifo_st_t;

    els_fifo_st_t st_q;
    els_fifo_st_t st_d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic full;
    logic empty;
    logic push;
    logic pop;

    assign empty = st_q.wp == st_q.rp;
    assign full = (st_q.wp[AW] != st_q.rp[AW]) &&
                  (st_q.wp[AW-1:0] == st_q.rp[AW-1:0]);
    assign in_ready = !full;
    assign out_valid = !empty;
    assign out_data = mem[st_q.rp[AW-1:0]];
    assign push = in_valid && !full;
    assign pop = out_ready && !empty;

    always_comb begin
        st_d = st_q;
        if (push) begin
            st_d.wp = st_q.wp + 1'b1;
        end
        if (pop) begin
            st_d.rp = st_q.rp + 1'b1;
        end
    end

    // storage has no reset: only pointers define contents
    always_ff @(posedge clock) begin
        if (push) begin
            mem[st_q.wp[AW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule : els_fifo

/* core/els_pkg.sv */
// Operation
// R1 - select pin chooses endian; variants force little
// R2 - big: first byte on lane three, descending
// R3 - little: first byte on lane zero, ascending
// R4 - big rom: 0000h lane three, 0003h lane zero
// R5 - little rom: 0000h lane zero, 0003h lane three
// R6 - fifo and register lanes never change
// R7 - slave register access works in both modes
// R8 - full words pass without byte repositioning
// R9 - narrow accesses adjust byte controls and decode
// R10 - register keeps lane, byte address remapped
// R11 - stream bytes kept in sequential order
// R12 - internal processor accesses always little endian
// R13 - host patches instructions in selected byte order
// R14 - select pin synchronised, applied between transactions
package els_pkg;
    // =========================================================
    // widths and sizes
    localparam int unsigned DATA_W = 32;
    localparam int unsigned BYTE_W = 8;
    localparam int unsigned LANES = 4;
    localparam int unsigned FIFO_DEPTH = 8;
    localparam int unsigned FIFO_AW = 3;
    localparam int unsigned REG_AW = 8;
    // =========================================================
    // reset values
    localparam logic MODE_RST = 1'b0;
    localparam logic [1:0] LANE_RST = 2'h0;
    // example register offset: little 00h, big 03h
    localparam logic [7:0] CTRL0_LE_OFS = 8'h00;
    localparam logic [7:0] CTRL0_BE_OFS = 8'h03;
    // =========================================================
    // host access kinds
    typedef enum logic [1:0] {
        ELS_ACC_BYTE,
        ELS_ACC_HALF,
        ELS_ACC_WORD,
        ELS_ACC_NONE
    } els_size_t;
    typedef enum logic [1:0] {
        ELS_SRC_REG,
        ELS_SRC_ROM,
        ELS_SRC_PROC
    } els_src_t;
endpackage : els_pkg

/* core/els_steer.sv */
`timescale 1ns/1ps
module els_steer #(
    parameter bit HAS_SELECT_PIN = 1'b1
) (
    input wire logic clock,
    input wire logic resetn,
    input wire logic big_endian_sel,
    // host bus side, one transaction per cycle with busy flag
    input wire logic host_busy,
    // scsi stream in (device to host), bytes in sequence
    input wire logic [7:0] rx_byte,
    input wire logic rx_valid,
    output logic rx_ready,
    input wire logic rx_last,
    // host word out
    output logic [31:0] host_wdata,
    output logic [3:0] host_wbe,
    output logic host_wvalid,
    input wire logic host_wready,
    // register / rom / internal access
    input wire logic acc_valid,
    input wire logic [1:0] acc_src,
    input wire logic [1:0] acc_size,
    input wire logic [7:0] acc_addr,
    input wire logic [31:0] acc_wdata,
    output logic [7:0] acc_reg_addr,
    output logic [3:0] acc_lane_en,
    output logic [31:0] acc_lane_data,
    output logic acc_done,
    output logic big_mode
);
    // =========================================================
    // state
    typedef struct packed {
        logic mode;
        logic [1:0] cnt;
        logic [31:0] word;
        logic [3:0] be;
        logic flush;
        logic [7:0] reg_addr;
        logic [3:0] lane_en;
        logic [31:0] lane_data;
        logic done;
    } els_st_t;

    els_st_t st_q;
    els_st_t st_d;
    logic pin_level;
    logic [31:0] f_data;
    logic f_valid;
    logic f_ready;
    logic in_take;
    logic [1:0] lane;
    logic acc_big;
    logic [1:0] off;
    logic [3:0] host_wbe_n;
    logic out_q_valid;
    logic [31:0] out_q_data;
    logic [3:0] out_q_be;

    // =========================================================
    // select pin
    els_sync u_sync (
        .clock(clock),
        .resetn(resetn),
        .pin(big_endian_sel),
        .level(pin_level)
    );

    // =========================================================
    // lane mapping
    function automatic logic [1:0] lane_of(input logic big,
                                           input logic [1:0] a);
        lane_of = big ? (2'h3 - a) : a; // R2 R3 R4 R5
    endfunction : lane_of

    function automatic logic [3:0] size_mask(input logic [1:0] sz);
        unique case (sz)
            els_pkg::ELS_ACC_BYTE: size_mask = 4'h1;
            els_pkg::ELS_ACC_HALF: size_mask = 4'h3;
            els_pkg::ELS_ACC_WORD: size_mask = 4'hF;
            default: size_mask = 4'h0;
        endcase
    endfunction : size_mask

    // word accesses bypass remap; processor side is always little
    assign acc_big = st_q.mode &&
        (acc_src != els_pkg::ELS_SRC_PROC) && // R12
        (acc_size != els_pkg::ELS_ACC_WORD); // R8
    assign off = acc_addr[1:0];
    assign lane = lane_of(st_q.mode, st_q.cnt);
    assign in_take = rx_valid && !st_q.flush;
    assign rx_ready = !st_q.flush;

    // =========================================================
    // next state
    always_comb begin
        st_d = st_q;
        st_d.done = 1'b0;
        // mode updates only while the host bus is idle
        if (!host_busy) begin
            st_d.mode = HAS_SELECT_PIN ? pin_level : 1'b0; // R1 R14
        end
        if (st_q.flush && f_ready) begin
            st_d.flush = 1'b0;
            st_d.cnt = els_pkg::LANE_RST;
            st_d.be = 4'h0;
            st_d.word = '0;
        end else if (in_take) begin
            // bytes fill in arrival order, first byte first
            st_d.word[8*lane +: 8] = rx_byte; // R11 R2 R3
            st_d.be[lane] = 1'b1; // R9
            st_d.cnt = st_q.cnt + 2'h1;
            st_d.flush = rx_last || (st_q.cnt == 2'h3);
        end
        if (acc_valid) begin
            // register keeps its lane; address is remapped
            if (acc_big && acc_size == els_pkg::ELS_ACC_BYTE) begin
                st_d.reg_addr = {acc_addr[7:2], 2'h3 - off}; // R10 R7
            end else if (acc_big) begin
                st_d.reg_addr = {acc_addr[7:2], 2'h2 - off}; // R10 R7
            end else begin
                st_d.reg_addr = acc_addr; // R8 R12
            end
            st_d.lane_en = acc_big ?
                (size_mask(acc_size) << st_d.reg_addr[1:0]) :
                (size_mask(acc_size) << off); // R9 R6
            st_d.lane_data = acc_wdata; // R6
            st_d.done = 1'b1;
        end
    end

    // =========================================================
    // fifo toward host: back-pressure stalls the stream
    els_fifo #(
        .WIDTH(els_pkg::DATA_W + els_pkg::LANES),
        .DEPTH(els_pkg::FIFO_DEPTH),
        .AW(els_pkg::FIFO_AW)
    ) u_fifo (
        .clock(clock),
        .resetn(resetn),
        .in_data({st_q.be, st_q.word}),
        .in_valid(st_q.flush),
        .in_ready(f_ready),
        .out_data({host_wbe_n, f_data}),
        .out_valid(f_valid),
        .out_ready(host_wready || !out_q_valid)
    );

    // output register so outputs come from flip-flops
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            out_q_valid <= 1'b0;
            out_q_data <= '0;
            out_q_be <= 4'h0;
        end else if (host_wready || !out_q_valid) begin
            out_q_valid <= f_valid;
            out_q_data <= f_data;
            out_q_be <= host_wbe_n;
        end
    end

    assign host_wvalid = out_q_valid;
    assign host_wdata = out_q_data;
    assign host_wbe = out_q_be;
    assign acc_reg_addr = st_q.reg_addr;
    assign acc_lane_en = st_q.lane_en;
    assign acc_lane_data = st_q.lane_data;
    assign acc_done = st_q.done;
    assign big_mode = st_q.mode;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule : els_steer

/* core/els_sync.sv */
`timescale 1ns/1ps
module els_sync (
    input wire logic clock,
    input wire logic resetn,
    input wire logic pin,
    output logic level
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic lvl;
    } els_sync_st_t;

    els_sync_st_t st_q;
    els_sync_st_t st_d;

    always_comb begin
        st_d = st_q;
        st_d.s1 = pin;
        st_d.s2 = st_q.s1;
        st_d.s3 = st_q.s2;
        // change counts only once stages two and three agree
        if (st_q.s2 == st_q.s3) begin
            st_d.lvl = st_q.s3;
        end
    end

    assign level = st_q.lvl;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end
endmodule : els_sync

/* sim/els_host_model.sv */
`timescale 1ns/1ps
// =====
// host taking words, stalls for stall plus one cycles before each accept
module els_host_model (
    input wire logic clock,
    input wire logic resetn,
    input wire logic host_wvalid,
    input wire logic [31:0] host_wdata,
    input wire logic [3:0] host_wbe,
    input wire logic [3:0] stall,
    output logic host_wready,
    output logic [31:0] got_data,
    output logic [3:0] got_be,
    output int n_got
);
    logic [3:0] wait_q;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            host_wready <= 1'b0;
            wait_q <= 4'h0;
            got_data <= 32'h00000000;
            got_be <= 4'h0;
            n_got <= 0;
        end else if (host_wvalid && host_wready) begin
            host_wready <= 1'b0;
            wait_q <= 4'h0;
            got_data <= host_wdata;
            got_be <= host_wbe;
            n_got <= n_got + 1;
        end else if (host_wvalid && wait_q >= stall) begin
            host_wready <= 1'b1;
        end else if (host_wvalid) begin
            wait_q <= wait_q + 4'h1;
        end
    end
endmodule : els_host_model

/* sim/els_steer_assertions.sv */
`timescale 1ns/1ps
// =====
// access and mode checks on the top ports
module els_steer_assertions (
    input wire logic clock,
    input wire logic resetn,
    input wire logic big_endian_sel,
    input wire logic host_busy,
    input wire logic acc_valid,
    input wire logic [1:0] acc_src,
    input wire logic [1:0] acc_size,
    input wire logic [7:0] acc_addr,
    input wire logic [7:0] acc_reg_addr,
    input wire logic acc_done,
    input wire logic big_mode
);
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    chk_done_follows: assert property (acc_valid |=> acc_done)
        else $error("access not done");
    chk_done_cause: assert property (acc_done |-> $past(acc_valid))
        else $error("stray done");
    chk_word_addr: assert property (acc_valid && acc_size == 2'h2
        |=> acc_reg_addr == $past(acc_addr)) else $error("word moved");
    chk_proc_little: assert property (acc_valid && acc_src == 2'h2
        |=> acc_reg_addr == $past(acc_addr)) else $error("proc moved");
    chk_byte_big: assert property (acc_valid && acc_size == 2'h0
        && acc_src == 2'h0 && big_mode
        |=> acc_reg_addr == ($past(acc_addr) ^ 8'h03)) else $error("big byte");
    chk_byte_little: assert property (acc_valid && acc_size == 2'h0
        && acc_src == 2'h0 && !big_mode
        |=> acc_reg_addr == $past(acc_addr)) else $error("little byte");
    chk_mode_frozen: assert property (host_busy |=> $stable(big_mode))
        else $error("mode moved while busy");
    chk_mode_settle: assert property ($rose(big_endian_sel) && !host_busy
        ##1 (!host_busy)[*5] |-> big_mode) else $error("mode not taken");
endmodule : els_steer_assertions

/* sim/test_endian_byte_lane_steering.sv */
`timescale 1ns/1ps
`define CHK(nm, ex, got) begin n_compared++; if ((got) !== (ex)) begin \
    failures++; $display("CHECK FAILED %s exp %0h got %0h", nm, ex, got); end end
module test_endian_byte_lane_steering;
    logic clock = 1'b0, resetn = 1'b0, big_endian_sel = 1'b0;
    logic host_busy = 1'b0, rx_valid = 1'b0, rx_last = 1'b0;
    logic acc_valid = 1'b0, rx_ready, host_wvalid, host_wready;
    logic acc_done, big_mode;
    logic [1:0] acc_src = 2'h0, acc_size = 2'h0;
    logic [7:0] rx_byte = 8'h00, acc_addr = 8'h00, acc_reg_addr;
    logic [31:0] acc_wdata = 32'h00000000, host_wdata, acc_lane_data;
    logic [31:0] got_data;
    logic [3:0] stall = 4'h0, host_wbe, acc_lane_en, got_be;
    int n_got;
    int failures = 0;
    int n_compared = 0;
    always #20 clock = ~clock;
    els_steer u_dut (.clock, .resetn, .big_endian_sel, .host_busy, .rx_byte,
        .rx_valid, .rx_ready, .rx_last, .host_wdata, .host_wbe, .host_wvalid,
        .host_wready, .acc_valid, .acc_src, .acc_size, .acc_addr, .acc_wdata,
        .acc_reg_addr, .acc_lane_en, .acc_lane_data, .acc_done, .big_mode);
    els_host_model u_host (.clock, .resetn, .host_wvalid, .host_wdata,
        .host_wbe, .stall, .host_wready, .got_data, .got_be, .n_got);
    task automatic final_report;
        if (failures == 0 && n_compared > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask : final_report
    task automatic give_up;
        failures++;
        final_report();
    endtask : give_up
    // =====
    // bus helpers; a byte is held until rx_ready is seen at an edge
    task automatic send(input logic [7:0] b, input logic last);
        int i;
        rx_byte <= b;
        rx_valid <= 1'b1;
        rx_last <= last;
        i = 0;
        do begin
            @(negedge clock);
            i++;
        end while (rx_ready !== 1'b1 && i < 500);
        if (i >= 500) give_up();
        @(posedge clock);
    endtask : send
    task automatic idle;
        rx_valid <= 1'b0;
        rx_last <= 1'b0;
        @(posedge clock);
    endtask : idle
    task automatic wait_word(input int n);
        for (int i = 0; i < 2000 && n_got < n; i++) @(negedge clock);
        if (n_got < n) give_up();
    endtask : wait_word
    task automatic set_mode(input logic m);
        big_endian_sel <= m;
        for (int i = 0; i < 20 && big_mode !== m; i++) @(negedge clock);
        `CHK("mode", m, big_mode)
        @(posedge clock);
    endtask : set_mode
    task automatic access(input logic [1:0] src, input logic [1:0] sz,
        input logic [7:0] a, input logic [7:0] ea, input logic [3:0] el);
        acc_valid <= 1'b1;
        acc_src <= src;
        acc_size <= sz;
        acc_addr <= a;
        acc_wdata <= {4{a ^ ea}};
        @(posedge clock);
        acc_valid <= 1'b0;
        @(negedge clock);
        `CHK("done", 1'b1, acc_done)
        `CHK("lane_data", {4{a ^ ea}}, acc_lane_data)
        if (src != 2'h1) `CHK("reg_addr", ea, acc_reg_addr)
        `CHK("lane_en", el, acc_lane_en)
        @(posedge clock);
    endtask : access
    // =====
    // scenarios
    task automatic t_access(input logic m);
        logic [7:0] b;
        set_mode(m);
        for (int a = 0; a < 4; a++) begin
            b = m ? 8'(a ^ 3) : 8'(a);
            access(2'h0, 2'h0, 8'(a), b, 4'h1 << b);
            access(2'h1, 2'h0, 8'(a), b, 4'h1 << b);
            access(2'h2, 2'h0, 8'(a), 8'(a), 4'h1 << a);
        end
        access(2'h0, 2'h1, 8'h00, m ? 8'h02 : 8'h00, m ? 4'hC : 4'h3);
        access(2'h0, 2'h1, 8'h02, m ? 8'h00 : 8'h02, m ? 4'h3 : 4'hC);
        access(2'h0, 2'h2, 8'h04, 8'h04, 4'hF);
    endtask : t_access
    task automatic t_stream(input logic m);
        int n;
        n = n_got;
        set_mode(m);
        for (int k = 1; k < 5; k++) send(8'(k * 17), 1'b0);
        send(8'h55, 1'b0);
        send(8'h66, 1'b1);
        idle();
        wait_word(n + 1);
        `CHK("word", m ? 32'h11223344 : 32'h44332211, got_data)
        wait_word(n + 2);
        `CHK("part_be", m ? 4'hC : 4'h3, got_be)
        `CHK("part", 16'h5566, m ? got_data[31:16] :
            {got_data[7:0], got_data[15:8]})
    endtask : t_stream
    task automatic t_freeze;
        host_busy <= 1'b1;
        big_endian_sel <= 1'b1;
        repeat (8) @(posedge clock);
        `CHK("frozen", 1'b0, big_mode)
        host_busy <= 1'b0;
        set_mode(1'b1);
    endtask : t_freeze
    // slow host fills the word buffer first with the eleventh word; rx_ready drops only in each word's flush cycle
    task automatic t_fill;
        int n;
        n = n_got;
        stall <= 4'hF;
        set_mode(1'b0);
        for (int k = 0; k < 48; k++) send(8'(k), 1'b0);
        idle();
        wait_word(n + 12);
        `CHK("words", n + 12, n_got)
        `CHK("last", 32'h2F2E2D2C, got_data)
    endtask : t_fill
    initial begin
        repeat (2) @(posedge clock);
        resetn <= 1'b1;
        @(posedge clock);
        t_access(1'b0);
        t_stream(1'b0);
        t_freeze();
        t_access(1'b1);
        t_stream(1'b1);
        t_fill();
        final_report();
    end
    initial begin
        repeat (100000) @(posedge clock);
        give_up();
    end
endmodule : test_endian_byte_lane_steering
bind els_steer els_steer_assertions u_chk (.clock, .resetn, .big_endian_sel,
    .host_busy, .acc_valid, .acc_src, .acc_size, .acc_addr, .acc_reg_addr,
    .acc_done, .big_mode);
